// [hdl/asb_cfg_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "asb_defines.svh"
module asb_cfg_decode
  import asb_pkg::*;
(
  asb_cfg_if.dec cfg
);
  logic [4:0]    first;
  asb_size_log_t sz;
  wire  [2:0]    rank;
  wire  [6:0]    mask_w;
  wire  [5:0]    blk_base;

  // ========================================================================
  // Buffer size from the code range
  always_comb begin
    if (cfg.bufc >= `ASB_FIRST_1024W) begin
      first = `ASB_FIRST_1024W;
      sz    = `ASB_LOG_1024W;
    end else if (cfg.bufc >= `ASB_FIRST_512W) begin
      first = `ASB_FIRST_512W;
      sz    = `ASB_LOG_512W;
    end else if (cfg.bufc >= `ASB_FIRST_256W) begin
      first = `ASB_FIRST_256W;
      sz    = `ASB_LOG_256W;
    end else if (cfg.bufc >= `ASB_FIRST_128W) begin
      first = `ASB_FIRST_128W;
      sz    = `ASB_LOG_128W;
    end else if (cfg.bufc >= `ASB_FIRST_64W) begin
      first = `ASB_FIRST_64W;
      sz    = `ASB_LOG_64W;
    end else if (cfg.bufc >= `ASB_FIRST_32W) begin
      first = `ASB_FIRST_32W;
      sz    = `ASB_LOG_32W;
    end else begin
      first = `ASB_FIRST_16W;
      sz    = `ASB_LOG_16W;
    end
  end

  // ========================================================================
  // Block size: rank 0 is one channel, then 8, 16, 32, 64
  assign rank          = 3'(cfg.bufc - first);
  assign cfg.size_log  = sz;
  assign cfg.blk_log   = (rank == 3'h0) ? `ASB_BLK1
                                        : 3'(rank + `ASB_RANK_OFS);
  assign mask_w        = 7'((7'h01 << cfg.blk_log) - 7'h01);
  assign cfg.chan_mask = mask_w[5:0];
  // Only the group bits that name an aligned block reach the base
  assign blk_base = {cfg.group[2:0], 3'h0};
  assign cfg.base = (cfg.blk_log == `ASB_BLK1) ? cfg.group
                  : (blk_base & ~cfg.chan_mask);
endmodule : asb_cfg_decode
`default_nettype wire

// [hdl/asb_cfg_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface asb_cfg_if;
  import asb_pkg::*;
  logic [4:0]    bufc;
  asb_chan_t     group;
  asb_size_log_t size_log;
  asb_blk_log_t  blk_log;
  asb_chan_t     base;
  asb_chan_t     chan_mask;
  modport dec  (input bufc, group,
                output size_log, blk_log, base, chan_mask);
  modport user (output bufc, group,
                input size_log, blk_log, base, chan_mask);
endinterface : asb_cfg_if
`default_nettype wire

// [hdl/asb_defines.svh]
`ifndef ASB_DEFINES_SVH
`define ASB_DEFINES_SVH
// ==========================================================================
// Register map
`define ASB_CSR_OFFSET    12'h002
`define ASB_CFG_OFFSET    12'h004
`define ASB_CFG_RESET     16'h0000
// ==========================================================================
// Configuration word fields
`define ASB_BUFC_HI       15
`define ASB_BUFC_LO       11
`define ASB_ISRC_BIT      10
`define ASB_GAIN_HI       9
`define ASB_GAIN_LO       8
`define ASB_SMODE_HI      7
`define ASB_SMODE_LO      6
`define ASB_GRP_HI        5
`define ASB_GRP_LO        0
`define ASB_CSR_ARMED_BIT 5
`define ASB_CSR_TRIG_BIT  4
`define ASB_SMODE_AUTO    2'h0
`define ASB_SMODE_SINGLE  2'h1
// ==========================================================================
// Buffer size as log2 of words
`define ASB_LOG_16W       4'h4
`define ASB_LOG_32W       4'h5
`define ASB_LOG_64W       4'h6
`define ASB_LOG_128W      4'h7
`define ASB_LOG_256W      4'h8
`define ASB_LOG_512W      4'h9
`define ASB_LOG_1024W     4'ha
// First buffer code of each buffer size
`define ASB_FIRST_16W     5'h00
`define ASB_FIRST_32W     5'h03
`define ASB_FIRST_64W     5'h07
`define ASB_FIRST_128W    5'h0c
`define ASB_FIRST_256W    5'h11
`define ASB_FIRST_512W    5'h16
`define ASB_FIRST_1024W   5'h1b
// Block size as log2 of channels
`define ASB_BLK1          3'h0
`define ASB_BLK8          3'h3
`define ASB_BLK16         3'h4
`define ASB_BLK32         3'h5
`define ASB_BLK64         3'h6
`define ASB_RANK_OFS      3'h2
`endif

// [hdl/asb_pkg.sv]
package asb_pkg;
  typedef enum logic [1:0] {ASB_IDLE, ASB_ARMED, ASB_SCAN} asb_state_e;
  typedef logic [3:0] asb_size_log_t;
  typedef logic [2:0] asb_blk_log_t;
  typedef logic [5:0] asb_chan_t;
  typedef logic [9:0] asb_addr_t;
endpackage : asb_pkg

// [hdl/asb_scan_config.sv]
// Operation
// - Scan mode 00 auto, 01 single, 1x random
// - Group field picks block or single channel
// - Single-channel codes fill buffer with one channel
// - Only programmed count of locations updated
// - Block 8: group bits 2:0 pick block
// - Block 16: group bits 2:1, bit 0 ignored
// - Block 32: group bit 2 picks half
// - Block 64: all channels, group ignored
// - 16-word codes 00000, 00001, 00010 decoded
// - 32-word codes 00011 to 00110 decoded
// - 64-word codes 00111 to 01011 decoded
// - 128-word codes 01100 to 10000 decoded
// - Don't-care bits never change scan behaviour
// - Source, gain, scan mode fields fixed positions
// - Random mode converts one channel into location 0
// - Auto re-arms at end; single stops
// - Buffer code held in bits 15 to 11
`timescale 1ns/1ps
`default_nettype none
`include "asb_defines.svh"
module asb_scan_config
  import asb_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        reg_sel_in,
  input  wire logic        reg_wr_in,
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [1:0]  reg_be_in,
  input  wire logic [15:0] reg_wdata_in,
  output var  logic [15:0] reg_rdata_out,
  output var  logic        reg_ack_out,
  input  wire logic        arm_in,
  input  wire logic        trigger_in,
  output var  logic        armed_out,
  output var  logic        triggered_out,
  output var  logic        conv_valid_out,
  output var  asb_chan_t   conv_chan_out,
  output var  asb_addr_t   conv_addr_out,
  output var  logic        scan_done_out,
  output var  logic        irq_source_sel_out,
  output var  logic [1:0]  gain_mode_out
);
  asb_cfg_if     cfg_bus ();
  asb_state_e    state_q, state_d;
  logic [15:0]   cfg_q;
  asb_addr_t     idx_q, size_mask_q;
  asb_chan_t     base_q, chan_mask_q, grp_q;
  asb_blk_log_t  blk_log_q;
  logic [1:0]    smode_q;

  // ========================================================================
  // Register port
  wire        cfg_hit = reg_sel_in && (reg_addr_in == `ASB_CFG_OFFSET);
  wire        csr_hit = reg_sel_in && (reg_addr_in == `ASB_CSR_OFFSET);
  wire        cfg_wr  = cfg_hit && reg_wr_in;
  wire [15:0] cfg_d   = {reg_be_in[1] ? reg_wdata_in[15:8] : cfg_q[15:8],
                         reg_be_in[0] ? reg_wdata_in[7:0]  : cfg_q[7:0]};
  wire [15:0] csr_armed = 16'h0001 << `ASB_CSR_ARMED_BIT;
  wire [15:0] csr_trig  = 16'h0001 << `ASB_CSR_TRIG_BIT;
  wire [15:0] csr_word  = ((state_q == ASB_ARMED) ? csr_armed : 16'h0000)
                        | ((state_q == ASB_SCAN)  ? csr_trig  : 16'h0000);
  wire [15:0] rdata_d  = (cfg_hit && !reg_wr_in) ? cfg_q
                       : (csr_hit && !reg_wr_in) ? csr_word : 16'h0000;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_q         <= `ASB_CFG_RESET;
      reg_rdata_out <= 16'h0000;
      reg_ack_out   <= 1'b0;
    end else begin
      cfg_q         <= cfg_wr ? cfg_d : cfg_q;
      reg_rdata_out <= rdata_d;
      reg_ack_out   <= reg_sel_in;
    end
  end

  assign irq_source_sel_out = cfg_q[`ASB_ISRC_BIT];
  assign gain_mode_out      = cfg_q[`ASB_GAIN_HI:`ASB_GAIN_LO];

  // ========================================================================
  // Configuration decode
  assign cfg_bus.bufc  = cfg_q[`ASB_BUFC_HI:`ASB_BUFC_LO];
  assign cfg_bus.group = cfg_q[`ASB_GRP_HI:`ASB_GRP_LO];

  asb_cfg_decode u_decode (
    .cfg (cfg_bus.dec)
  );

  wire [10:0] size_mask_w = 11'((11'h001 << cfg_bus.size_log) - 11'h001);

  // ========================================================================
  // Scan sequencer
  wire       is_random = smode_q[1];
  wire       is_auto   = (smode_q == `ASB_SMODE_AUTO);
  wire       fire_rnd  = (state_q == ASB_ARMED) && trigger_in && is_random;
  wire       start     = (state_q == ASB_ARMED) && trigger_in && !is_random;
  wire       scan_end  = (state_q == ASB_SCAN) && (idx_q == size_mask_q);
  wire       arm_now   = ((state_q == ASB_IDLE) && arm_in)
                       || (scan_end && is_auto);
  wire [5:0] scan_chan = base_q | (idx_q[5:0] & chan_mask_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ASB_IDLE:  if (arm_in) state_d = ASB_ARMED;
      ASB_ARMED: if (start) state_d = ASB_SCAN;
      ASB_SCAN:  if (scan_end) state_d = is_auto ? ASB_SCAN
                                                 : ASB_ARMED;
      default:   state_d = ASB_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q     <= ASB_IDLE;
      size_mask_q <= 10'h000;
      chan_mask_q <= 6'h00;
      base_q      <= 6'h00;
      grp_q       <= 6'h00;
      blk_log_q   <= `ASB_BLK1;
      smode_q     <= `ASB_SMODE_AUTO;
    end else begin
      state_q <= state_d;
      if (arm_now) begin
        size_mask_q <= size_mask_w[9:0];
        chan_mask_q <= cfg_bus.chan_mask;
        base_q      <= cfg_bus.base;
        grp_q       <= cfg_bus.group;
        blk_log_q   <= cfg_bus.blk_log;
        smode_q     <= cfg_q[`ASB_SMODE_HI:`ASB_SMODE_LO];
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      idx_q          <= 10'h000;
      conv_valid_out <= 1'b0;
      conv_chan_out  <= 6'h00;
      conv_addr_out  <= 10'h000;
      scan_done_out  <= 1'b0;
      armed_out      <= 1'b0;
      triggered_out  <= 1'b0;
    end else begin
      idx_q          <= (state_q == ASB_SCAN && !scan_end) ?
                        10'(idx_q + 10'h001) : 10'h000;
      conv_valid_out <= (state_q == ASB_SCAN) || fire_rnd;
      conv_chan_out  <= fire_rnd ? grp_q : scan_chan;
      conv_addr_out  <= fire_rnd ? 10'h000 : idx_q;
      scan_done_out  <= scan_end || fire_rnd;
      armed_out      <= (state_d == ASB_ARMED);
      triggered_out  <= (state_d == ASB_SCAN);
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  wire in_scan = (state_q == ASB_SCAN);

  chk_dec_16w: assert property (
    (cfg_bus.bufc == 5'h02) |->
      cfg_bus.size_log == `ASB_LOG_16W && cfg_bus.blk_log == `ASB_BLK16)
    else $error("16-word buffer code decoded wrongly");
  chk_dec_32w: assert property (
    (cfg_bus.bufc == 5'h06) |->
      cfg_bus.size_log == `ASB_LOG_32W && cfg_bus.blk_log == `ASB_BLK32)
    else $error("32-word buffer code decoded wrongly");
  chk_dec_64w: assert property (
    (cfg_bus.bufc == 5'h0b) |->
      cfg_bus.size_log == `ASB_LOG_64W && cfg_bus.blk_log == `ASB_BLK64)
    else $error("64-word buffer code decoded wrongly");
  chk_dec_128w: assert property (
    (cfg_bus.bufc == 5'h0d) |->
      cfg_bus.size_log == `ASB_LOG_128W && cfg_bus.blk_log == `ASB_BLK8)
    else $error("128-word buffer code decoded wrongly");
  chk_addr_bound: assert property (
    conv_valid_out |-> (conv_addr_out & ~$past(size_mask_q)) == 10'h000)
    else $error("Update outside programmed buffer size");
  chk_one_chan: assert property (
    in_scan && blk_log_q == `ASB_BLK1 |=> conv_chan_out == $past(grp_q))
    else $error("Single-channel fill used another channel");
  chk_block_eight: assert property (
    in_scan && blk_log_q == `ASB_BLK8 |=>
      conv_chan_out[5:3] == $past(grp_q[2:0]))
    else $error("Block of 8 not aligned to group");
  chk_block_sixteen: assert property (
    in_scan && blk_log_q == `ASB_BLK16 |=>
      conv_chan_out[5:4] == $past(grp_q[2:1]))
    else $error("Block of 16 not aligned to group");
  chk_block_half: assert property (
    in_scan && blk_log_q == `ASB_BLK32 |=>
      conv_chan_out[5] == $past(grp_q[2]))
    else $error("Block of 32 picks wrong half");
  chk_block_all: assert property (
    in_scan && blk_log_q == `ASB_BLK64 |=>
      conv_chan_out == $past(idx_q[5:0]))
    else $error("Block of 64 does not walk all channels");
  chk_rand_loc: assert property (
    fire_rnd |=> conv_valid_out && conv_addr_out == 10'h000
      && conv_chan_out == $past(grp_q) && armed_out)
    else $error("Random access conversion misplaced");
  chk_single_stop: assert property (
    scan_end && !is_auto |=> state_q == ASB_ARMED && !triggered_out)
    else $error("Single scan did not stop at buffer end");
  chk_auto_rearm: assert property (
    scan_end && is_auto |=> in_scan ##1 conv_addr_out == 10'h000)
    else $error("Auto scan did not restart");
  chk_latch_hold: assert property (
    in_scan && !scan_end |=> $stable(size_mask_q) && $stable(base_q))
    else $error("Settings changed during a scan");

  cov_auto_wrap:   cover property (scan_end && is_auto);
  cov_single_end:  cover property (scan_end && !is_auto);
  cov_random_conv: cover property (fire_rnd);
  cov_write_mid:   cover property (in_scan && cfg_wr);
endmodule : asb_scan_config
`default_nettype wire

// [verification/asb_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Host side of the configuration register port
module asb_host_model (
  input  wire logic        clk_in,
  output var  logic        sel_out,
  output var  logic        wr_out,
  output var  logic [11:0] addr_out,
  output var  logic [1:0]  be_out,
  output var  logic [15:0] wdata_out
);
  initial begin
    sel_out   = 1'b0;
    wr_out    = 1'b0;
    addr_out  = 12'h000;
    be_out    = 2'b00;
    wdata_out = 16'h0000;
  end
  // One access, held over its taking edge, then released lines show garbage
  task automatic access(input logic w, input logic [11:0] a,
                        input logic [1:0] b, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    sel_out   = 1'b1;
    wr_out    = w;
    addr_out  = a;
    be_out    = b;
    wdata_out = d;
    @(posedge clk_in);
    #1;
    sel_out   = 1'b0;
    wr_out    = ~w;
    addr_out  = ~a;
    be_out    = ~b;
    wdata_out = ~d;
  endtask : access
endmodule : asb_host_model
`default_nettype wire

// [verification/asb_scan_config_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module asb_scan_config_bench;
  import asb_pkg::*;
  logic        clk_in;
  logic        reset_n_in;
  logic        arm_in;
  logic        trigger_in;
  logic        sel;
  logic        wr;
  logic [11:0] addr;
  logic [1:0]  be;
  logic [15:0] wdata;
  logic [15:0] reg_rdata_out;
  logic        reg_ack_out;
  logic        armed_out;
  logic        triggered_out;
  logic        conv_valid_out;
  asb_chan_t   conv_chan_out;
  asb_addr_t   conv_addr_out;
  wire  [15:0] conv_word = {conv_addr_out, conv_chan_out};
  logic        scan_done_out;
  logic        irq_source_sel_out;
  logic [1:0]  gain_mode_out;
  logic [15:0] q_rd[$];
  logic        q_kind[$];
  logic [15:0] q_conv[$];
  logic [15:0] q_end[$];
  logic [15:0] cfg_w;
  logic [31:0] seed;
  logic        mon_on;
  int          err_count;
  int          cmp_count;
  int          c;
  // ========================================================================
  // Design and host
  asb_scan_config uut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_sel_in(sel), .reg_wr_in(wr), .reg_addr_in(addr), .reg_be_in(be),
    .reg_wdata_in(wdata), .reg_rdata_out(reg_rdata_out),
    .reg_ack_out(reg_ack_out), .arm_in(arm_in), .trigger_in(trigger_in),
    .armed_out(armed_out), .triggered_out(triggered_out),
    .conv_valid_out(conv_valid_out),
    .conv_chan_out(conv_chan_out), .conv_addr_out(conv_addr_out),
    .scan_done_out(scan_done_out), .irq_source_sel_out(irq_source_sel_out),
    .gain_mode_out(gain_mode_out));
  asb_host_model host (.clk_in(clk_in), .sel_out(sel), .wr_out(wr),
    .addr_out(addr), .be_out(be), .wdata_out(wdata));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // ========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr
  task automatic chk_val(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val
  task automatic print_verdict();
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic wrr(input logic [11:0] a, input logic [1:0] b,
                     input logic [15:0] d);
    q_kind.push_back(1'b0);
    host.access(1'b1, a, b, d);
  endtask : wrr
  task automatic rdr(input logic [11:0] a, input logic [15:0] exp);
    q_kind.push_back(1'b1);
    q_rd.push_back(exp);
    host.access(1'b0, a, 2'b00, 16'h0000);
  endtask : rdr
  task automatic pulse(input logic is_trig);
    @(posedge clk_in);
    #1;
    if (is_trig) trigger_in = 1'b1;
    else arm_in = 1'b1;
    @(posedge clk_in);
    #1;
    trigger_in = 1'b0;
    arm_in     = 1'b0;
  endtask : pulse
  task automatic wait_hi(input logic for_done);
    int n;
    for (n = 0; n < 2000; n++) begin
      @(negedge clk_in);
      if ((for_done ? scan_done_out : armed_out) === 1'b1) break;
    end
    if (n == 2000) chk_val("wait", 16'h0001, 16'h0000);
  endtask : wait_hi
  task automatic do_reset();
    @(posedge clk_in);
    #1;
    reset_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
  endtask : do_reset
  // Expected conversions of one scan: sizes 16 and 32 own 3 and 4 codes,
  // every larger size owns 5, each starting with its one-channel block
  task automatic push_exp(input logic [15:0] cfg);
    int k, lsz, lblk, a, n;
    logic [5:0] g, base, m;
    k = int'(cfg[15:11]);
    g = cfg[5:0];
    lsz = 4;
    n = 3;
    while (lsz < 10 && k >= n) begin
      k = k - n;
      lsz++;
      n = (lsz < 6) ? 4 : 5;
    end
    lblk = (k == 0) ? 0 : k + 2;
    m = 6'((1 << lblk) - 1);
    base = (lblk == 0) ? g : (6'((g & 6'h07) << 3) & ~m);
    if (cfg[7]) begin
      q_conv.push_back({10'h000, g});
      q_end.push_back(16'h0001);
    end else begin
      for (a = 0; a < (1 << lsz); a++) begin
        q_conv.push_back({10'(a), base | (6'(a) & m)});
        q_end.push_back(16'(a == (1 << lsz) - 1));
      end
    end
  endtask : push_exp
  task automatic run(input logic [15:0] cfg, input int ntrig);
    int t;
    do_reset();
    wrr(12'h004, 2'b11, cfg);
    pulse(1'b0);
    wait_hi(1'b0);
    wrr(12'h002, 2'b11, 16'hffff);
    rdr(12'h002, 16'h0020);
    for (t = 0; t < ntrig; t++) begin
      push_exp(cfg);
      pulse(1'b1);
      chk_val("trig", {15'h0000, !cfg[7]}, 16'(triggered_out));
      wait_hi(1'b1);
      chk_val("armed", 16'h0001, {15'h0000, armed_out});
      chk_val("trig", 16'h0000, 16'(triggered_out));
    end
  endtask : run
  // ========================================================================
  // Result monitor
  always @(negedge clk_in) begin
    if (reg_ack_out === 1'b1 && q_kind.size() > 0) begin
      if (q_kind.pop_front())
        chk_val("rdata", q_rd.pop_front(), reg_rdata_out);
    end
    if (conv_valid_out === 1'b1 && q_conv.size() > 0) begin
      chk_val("conv", q_conv.pop_front(), conv_word);
      chk_val("done", q_end.pop_front(), 16'(scan_done_out));
    end else if (conv_valid_out === 1'b1 && mon_on) begin
      chk_val("conv extra", 16'h0000, 16'(conv_valid_out));
    end
  end
  initial begin
    #100000;
    chk_val("watchdog", 16'h0001, 16'h0000);
    print_verdict();
  end
  // ========================================================================
  // Main sequence
  initial begin
    reset_n_in = 1'b0;
    arm_in     = 1'b0;
    trigger_in = 1'b0;
    err_count  = 0;
    cmp_count  = 0;
    mon_on     = 1'b1;
    seed       = 32'hc300_472f;
    repeat (5) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    rdr(12'h004, 16'h0000);
    seed = lfsr(seed);
    wrr(12'h004, 2'b11, seed[15:0]);
    rdr(12'h004, seed[15:0]);
    chk_val("src", 16'(seed[10]), 16'(irq_source_sel_out));
    chk_val("gain", 16'(seed[9:8]), 16'(gain_mode_out));
    wrr(12'h004, 2'b01, ~seed[15:0]);
    rdr(12'h004, {seed[15:8], ~seed[7:0]});
    rdr(12'h00a, 16'h0000);
    // Every buffer code; the 64-channel variant is assumed, so any group
    // exists, and group bits outside the block are random don't-cares
    for (c = 0; c < 32; c++) begin
      seed = lfsr(seed);
      cfg_w = {5'(c), seed[10:8], 2'b01, seed[5:0]};
      run(cfg_w, 1);
    end
    seed = lfsr(seed);
    run({5'h07, 3'b000, 1'b1, seed[6], seed[5:0]}, 2);
    // Auto mode relatches the config written mid-scan
    do_reset();
    wrr(12'h004, 2'b11, 16'h0802);
    pulse(1'b0);
    wait_hi(1'b0);
    push_exp(16'h0802);
    push_exp(16'h1006);
    pulse(1'b1);
    wrr(12'h004, 2'b11, 16'h1006);
    rdr(12'h002, 16'h0010);
    wait_hi(1'b1);
    wait_hi(1'b1);
    // Let the monitor take the last conversion before counting leftovers
    @(posedge clk_in);
    mon_on = 1'b0;
    chk_val("left", 16'h0000, 16'(q_conv.size() + q_end.size()));
    print_verdict();
  end
endmodule : asb_scan_config_bench
`default_nettype wire
